// [core/ppc_pkg.sv]
// Constants for the port pin configuration register block.
// Assumes an 8-bit special-function register bus with a separate page-select level.
package ppc_pkg;
  localparam logic [7:0] ADDR_PORT3_DATA   = 8'hb0;
  localparam logic [7:0] ADDR_P0_SHARED_A  = 8'hb1;
  localparam logic [7:0] ADDR_P0_SHARED_B  = 8'hb2;
  localparam logic [7:0] ADDR_P1_SHARED_A  = 8'hb3;
  localparam logic [7:0] ADDR_P1_SHARED_B  = 8'hb4;
  localparam logic [7:0] ADDR_PIN20_SETUP  = 8'hb5;
  localparam logic [7:0] RST_PORT3_DATA    = 8'h01;
  localparam logic [7:0] RST_MODE_SEL_A    = 8'hff;
  localparam logic [7:0] RST_MODE_SEL_B    = 8'h00;
  localparam logic [7:0] RST_SCHMITT       = 8'h00;
  localparam logic [7:0] RST_SLEW          = 8'h00;
  localparam logic [7:0] RST_PIN20_SETUP   = 8'h00;
  localparam int         BIT_PULLUP        = 7;
  localparam int         BIT_TIMER_B_OE    = 3;
  localparam int         BIT_TIMER_A_OE    = 2;
  localparam int         BIT_PIN20_SCHMITT = 0;
  localparam logic [7:0] PIN20_SETUP_MASK  = 8'h8d;
  localparam logic [1:0] MODE_QUASI        = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL    = 2'h1;
  localparam logic [1:0] MODE_INPUT_ONLY   = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN   = 2'h3;
endpackage : ppc_pkg

// [core/ppc_port_cfg.sv]
// Port pin configuration registers: port 3 data bit, port 0/1 mode, Schmitt and slew, pin 2.0 setup.
// Assumes a single-cycle register strobe bus on I_MCLK and a page-select level from the core.
// How it works
// - Port 3 data bits 7..1 always read as zero.
// - Port 3 bit 0 is general I/O only with the internal oscillator.
// - Otherwise bit 0 is clock input; writes ignored, reads zero.
// - Mode bits a,b per pin: 00 quasi, 01 push-pull, 10 input, 11 open-drain.
// - Schmitt-select bit set gives Schmitt input, cleared gives TTL.
// - Slew bit set gives high-speed edges, cleared gives normal slew.
// - Mode registers at page 0, Schmitt and slew at page 1, same addresses.
// - Bit 7 enables pin 2.0 pull-up only while the reset-pin-disable bit is 0.
// - Pin 2.0 keeps its pull-up always on while the reset-pin-disable bit is 1.
// - Bit 3 routes timer B output to its pin when set.
// - Bit 2 routes timer A output to its pin when set.
// - Bit 0 selects pin 2.0 Schmitt input when set, TTL when cleared.
// - Port 3 data supports single-bit set, clear and test accesses.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module ppc_port_cfg
  import ppc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         I_MCLK,
  input  wire logic         I_SYS_RST,
  input  wire logic [7:0]   I_ADDR,
  input  wire logic [7:0]   I_WDATA,
  input  wire logic         I_WR,
  input  wire logic         I_RD,
  input  wire logic         I_BIT_OP,
  input  wire logic [2:0]   I_BIT_SEL,
  input  wire logic         I_BIT_VAL,
  input  wire logic         I_PAGE,
  input  wire logic         I_INT_OSC_SEL,
  input  wire logic         I_RESET_PIN_DISABLE_CFG,
  input  wire logic         I_PORT3_BIT0_PIN,
  input  wire logic         I_TIMER_A_OUT,
  input  wire logic         I_TIMER_B_OUT,
  output logic      [7:0]   O_RDATA,
  output logic              O_BIT_RDATA,
  output logic      [2*W-1:0] O_PORT0_MODE,
  output logic      [2*W-1:0] O_PORT1_MODE,
  output logic      [W-1:0] O_PORT0_SCHMITT,
  output logic      [W-1:0] O_PORT1_SCHMITT,
  output logic      [W-1:0] O_PORT0_SLEW_FAST,
  output logic      [W-1:0] O_PORT1_SLEW_FAST,
  output logic              O_PORT3_BIT0_OUT,
  output logic              O_PORT3_GPIO_EN,
  output logic              O_EXTERNAL_CLOCK_INPUT,
  output logic              O_PIN20_PULLUP,
  output logic              O_PIN20_SCHMITT,
  output logic              O_TIMER_A_PIN,
  output logic              O_TIMER_A_PIN_OE,
  output logic              O_TIMER_B_PIN,
  output logic              O_TIMER_B_PIN_OE
);

  logic         port3_bit0_q;
  logic [W-1:0] p0_mode_a_q, p0_mode_b_q, p0_schmitt_q, p0_slew_q;
  logic [W-1:0] p1_mode_a_q, p1_mode_b_q, p1_schmitt_q, p1_slew_q;
  logic [7:0]   pin20_setup_q;
  logic         pin_meta_q, pin_sync_q;
  logic         osc_meta_q, osc_sync_q;
  logic [7:0]   rdata_d;
  logic         port3_read_bit;
  logic         page0, page1;
  logic         wr_p3_byte, wr_p3_bit;

  // The oscillator select and pin may change outside this clock, so both pass two flops.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      osc_meta_q <= 1'b0;
      osc_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= I_PORT3_BIT0_PIN;
      pin_sync_q <= pin_meta_q;
      osc_meta_q <= I_INT_OSC_SEL;
      osc_sync_q <= osc_meta_q;
    end
  end

  assign page0      = ~I_PAGE;
  assign page1      = I_PAGE;
  assign wr_p3_byte = I_WR && !I_BIT_OP && (I_ADDR == ADDR_PORT3_DATA);
  assign wr_p3_bit  = I_WR && I_BIT_OP && (I_ADDR == ADDR_PORT3_DATA) && (I_BIT_SEL == 3'h0);

  // Writes to port 3 bit 0 only land while the internal oscillator clocks the part.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      port3_bit0_q <= RST_PORT3_DATA[0];
    end else if (osc_sync_q) begin
      if (wr_p3_byte) begin
        port3_bit0_q <= I_WDATA[0];
      end else if (wr_p3_bit) begin
        port3_bit0_q <= I_BIT_VAL;
      end
    end
  end

  // Mode registers share addresses with Schmitt and slew registers; the page picks the target.
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      p0_mode_a_q  <= RST_MODE_SEL_A;
      p0_mode_b_q  <= RST_MODE_SEL_B;
      p0_schmitt_q <= RST_SCHMITT;
      p0_slew_q    <= RST_SLEW;
      p1_mode_a_q  <= RST_MODE_SEL_A;
      p1_mode_b_q  <= RST_MODE_SEL_B;
      p1_schmitt_q <= RST_SCHMITT;
      p1_slew_q    <= RST_SLEW;
    end else if (I_WR && !I_BIT_OP) begin
      case (I_ADDR)
        ADDR_P0_SHARED_A: begin
          if (page0) p0_mode_a_q <= I_WDATA;
          else p0_schmitt_q <= I_WDATA;
        end
        ADDR_P0_SHARED_B: begin
          if (page0) p0_mode_b_q <= I_WDATA;
          else p0_slew_q <= I_WDATA;
        end
        ADDR_P1_SHARED_A: begin
          if (page0) p1_mode_a_q <= I_WDATA;
          else p1_schmitt_q <= I_WDATA;
        end
        ADDR_P1_SHARED_B: begin
          if (page0) p1_mode_b_q <= I_WDATA;
          else p1_slew_q <= I_WDATA;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      pin20_setup_q <= RST_PIN20_SETUP;
    end else if (I_WR && !I_BIT_OP && I_ADDR == ADDR_PIN20_SETUP) begin
      pin20_setup_q <= I_WDATA & PIN20_SETUP_MASK;
    end
  end

  // Port 3 reads show the pin while in general I/O use, zero when it is the clock input.
  assign port3_read_bit = osc_sync_q & pin_sync_q;

  always_comb begin
    rdata_d = 8'h00;
    case (I_ADDR)
      ADDR_PORT3_DATA:  rdata_d = {7'h00, port3_read_bit};
      ADDR_P0_SHARED_A: rdata_d = page1 ? p0_schmitt_q : p0_mode_a_q;
      ADDR_P0_SHARED_B: rdata_d = page1 ? p0_slew_q : p0_mode_b_q;
      ADDR_P1_SHARED_A: rdata_d = page1 ? p1_schmitt_q : p1_mode_a_q;
      ADDR_P1_SHARED_B: rdata_d = page1 ? p1_slew_q : p1_mode_b_q;
      ADDR_PIN20_SETUP: rdata_d = pin20_setup_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_RDATA     <= 8'h00;
      O_BIT_RDATA <= 1'b0;
    end else begin
      O_RDATA     <= I_RD ? rdata_d : 8'h00;
      O_BIT_RDATA <= I_RD && I_BIT_OP && (I_ADDR == ADDR_PORT3_DATA) && (I_BIT_SEL == 3'h0)
                     && port3_read_bit;
    end
  end

  // Each pin's mode is a then b, giving the two-bit mode code.
  for (genvar n = 0; n < W; n++) begin : g_mode
    assign O_PORT0_MODE[2*n+1:2*n] = {p0_mode_a_q[n], p0_mode_b_q[n]};
    assign O_PORT1_MODE[2*n+1:2*n] = {p1_mode_a_q[n], p1_mode_b_q[n]};
  end

  assign O_PORT0_SCHMITT   = p0_schmitt_q;
  assign O_PORT1_SCHMITT   = p1_schmitt_q;
  assign O_PORT0_SLEW_FAST = p0_slew_q;
  assign O_PORT1_SLEW_FAST = p1_slew_q;

  assign O_PORT3_BIT0_OUT       = port3_bit0_q;
  assign O_PORT3_GPIO_EN        = osc_sync_q;
  assign O_EXTERNAL_CLOCK_INPUT = ~osc_sync_q;

  // A set reset-pin-disable bit forces the pull-up on, whatever bit 7 holds.
  assign O_PIN20_PULLUP  = I_RESET_PIN_DISABLE_CFG | pin20_setup_q[BIT_PULLUP];
  assign O_PIN20_SCHMITT = pin20_setup_q[BIT_PIN20_SCHMITT];

  // Timer outputs in counter mode would fight the count input; software must avoid that.
  assign O_TIMER_A_PIN_OE = pin20_setup_q[BIT_TIMER_A_OE];
  assign O_TIMER_A_PIN    = O_TIMER_A_PIN_OE & I_TIMER_A_OUT;
  assign O_TIMER_B_PIN_OE = pin20_setup_q[BIT_TIMER_B_OE];
  assign O_TIMER_B_PIN    = O_TIMER_B_PIN_OE & I_TIMER_B_OUT;

  property p_port3_high_zero;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      $past(I_RD) |-> O_RDATA[7:1] == 7'h00 || $past(I_ADDR) != ADDR_PORT3_DATA;
  endproperty
  a_port3_high_zero: assert property (p_port3_high_zero) else $error("port3 high bits not zero");

  property p_ext_clk_read_zero;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && I_ADDR == ADDR_PORT3_DATA && !osc_sync_q) |=> O_RDATA == 8'h00;
  endproperty
  a_ext_clk_read_zero: assert property (p_ext_clk_read_zero) else $error("port3 read not zero on ext clock");

  property p_ext_clk_write_ignored;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !osc_sync_q |=> $stable(port3_bit0_q);
  endproperty
  a_ext_clk_write_ignored: assert property (p_ext_clk_write_ignored) else $error("ext clock write landed");

  property p_gpio_write;
    @(posedge I_MCLK) disable iff (I_SYS_RST) (osc_sync_q && wr_p3_byte) |=> port3_bit0_q == $past(I_WDATA[0]);
  endproperty
  a_gpio_write: assert property (p_gpio_write) else $error("port3 write lost");

  property p_mode_pair;
    @(posedge I_MCLK) disable iff (I_SYS_RST) O_PORT0_MODE[1:0] == {p0_mode_a_q[0], p0_mode_b_q[0]};
  endproperty
  a_mode_pair: assert property (p_mode_pair) else $error("mode pair order wrong");

  property p_page1_write;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && !I_BIT_OP && page1 && I_ADDR == ADDR_P0_SHARED_B)
      |=> p0_slew_q == $past(I_WDATA) && $stable(p0_mode_b_q);
  endproperty
  a_page1_write: assert property (p_page1_write) else $error("page1 write misrouted");

  property p_pullup_reset_pin;
    @(posedge I_MCLK) disable iff (I_SYS_RST) I_RESET_PIN_DISABLE_CFG |-> O_PIN20_PULLUP;
  endproperty
  a_pullup_reset_pin: assert property (p_pullup_reset_pin) else $error("reset pin pull-up off");

  property p_timer_b_gate;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !pin20_setup_q[BIT_TIMER_B_OE] |-> !O_TIMER_B_PIN && !O_TIMER_B_PIN_OE;
  endproperty
  a_timer_b_gate: assert property (p_timer_b_gate) else $error("timer B output leaks");

  property p_bit_set;
    @(posedge I_MCLK) disable iff (I_SYS_RST) (osc_sync_q && wr_p3_bit) |=> port3_bit0_q == $past(I_BIT_VAL);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit write lost");

  property p_port3_read_pin;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && I_ADDR == ADDR_PORT3_DATA && osc_sync_q) |=> O_RDATA == {7'h00, $past(pin_sync_q)};
  endproperty
  a_port3_read_pin: assert property (p_port3_read_pin) else $error("port3 read lost pin level");

  property p_clock_pin_exclusive;
    @(posedge I_MCLK) disable iff (I_SYS_RST) O_EXTERNAL_CLOCK_INPUT == !O_PORT3_GPIO_EN;
  endproperty
  a_clock_pin_exclusive: assert property (p_clock_pin_exclusive) else $error("pin both clock and gpio");

  property p_ext_clk_bit_zero;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && I_BIT_OP && I_ADDR == ADDR_PORT3_DATA && !osc_sync_q) |=> !O_BIT_RDATA;
  endproperty
  a_ext_clk_bit_zero: assert property (p_ext_clk_bit_zero) else $error("bit test not zero on ext clock");

  property p_mode_pair_top;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      O_PORT1_MODE[2*W-1:2*W-2] == {p1_mode_a_q[W-1], p1_mode_b_q[W-1]};
  endproperty
  a_mode_pair_top: assert property (p_mode_pair_top) else $error("top pin mode pair wrong");

  property p_mode_open_drain;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (p0_mode_a_q[0] && p0_mode_b_q[0]) |-> O_PORT0_MODE[1:0] == MODE_OPEN_DRAIN;
  endproperty
  a_mode_open_drain: assert property (p_mode_open_drain) else $error("open-drain code wrong");

  property p_mode_input_only;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (p1_mode_a_q[0] && !p1_mode_b_q[0]) |-> O_PORT1_MODE[1:0] == MODE_INPUT_ONLY;
  endproperty
  a_mode_input_only: assert property (p_mode_input_only) else $error("input-only code wrong");

  property p_mode_quasi;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (!p0_mode_a_q[W-1] && !p0_mode_b_q[W-1]) |-> O_PORT0_MODE[2*W-1:2*W-2] == MODE_QUASI;
  endproperty
  a_mode_quasi: assert property (p_mode_quasi) else $error("quasi code wrong");

  property p_schmitt_write;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && !I_BIT_OP && page1 && I_ADDR == ADDR_P1_SHARED_A) |=> O_PORT1_SCHMITT == $past(I_WDATA);
  endproperty
  a_schmitt_write: assert property (p_schmitt_write) else $error("schmitt select write lost");

  property p_slew_write;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && !I_BIT_OP && page1 && I_ADDR == ADDR_P1_SHARED_B) |=> O_PORT1_SLEW_FAST == $past(I_WDATA);
  endproperty
  a_slew_write: assert property (p_slew_write) else $error("slew select write lost");

  property p_page0_write;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && !I_BIT_OP && page0 && I_ADDR == ADDR_P0_SHARED_A)
      |=> p0_mode_a_q == $past(I_WDATA) && $stable(p0_schmitt_q);
  endproperty
  a_page0_write: assert property (p_page0_write) else $error("page0 write misrouted");

  property p_page1_read;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && page1 && I_ADDR == ADDR_P1_SHARED_B) |=> O_RDATA == $past(p1_slew_q);
  endproperty
  a_page1_read: assert property (p_page1_read) else $error("page1 read misrouted");

  property p_unmapped_read;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && (I_ADDR < ADDR_PORT3_DATA || I_ADDR > ADDR_PIN20_SETUP)) |=> O_RDATA == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_rdata_idle;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !I_RD |=> O_RDATA == 8'h00 && !O_BIT_RDATA;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data held past its cycle");

  property p_pullup_bit;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      !I_RESET_PIN_DISABLE_CFG |-> O_PIN20_PULLUP == pin20_setup_q[BIT_PULLUP];
  endproperty
  a_pullup_bit: assert property (p_pullup_bit) else $error("pull-up ignores its enable bit");

  property p_timer_a_gate;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !pin20_setup_q[BIT_TIMER_A_OE] |-> !O_TIMER_A_PIN && !O_TIMER_A_PIN_OE;
  endproperty
  a_timer_a_gate: assert property (p_timer_a_gate) else $error("timer A output leaks");

  property p_timer_a_route;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      pin20_setup_q[BIT_TIMER_A_OE] |-> O_TIMER_A_PIN_OE && O_TIMER_A_PIN == I_TIMER_A_OUT;
  endproperty
  a_timer_a_route: assert property (p_timer_a_route) else $error("timer A output not routed");

  property p_timer_b_route;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      pin20_setup_q[BIT_TIMER_B_OE] |-> O_TIMER_B_PIN_OE && O_TIMER_B_PIN == I_TIMER_B_OUT;
  endproperty
  a_timer_b_route: assert property (p_timer_b_route) else $error("timer B output not routed");

  property p_pin20_schmitt_write;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && !I_BIT_OP && I_ADDR == ADDR_PIN20_SETUP) |=> O_PIN20_SCHMITT == $past(I_WDATA[BIT_PIN20_SCHMITT]);
  endproperty
  a_pin20_schmitt_write: assert property (p_pin20_schmitt_write) else $error("pin 2.0 schmitt write lost");

  property p_bit_test;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && I_BIT_OP && I_ADDR == ADDR_PORT3_DATA && I_BIT_SEL == 3'h0) |=> O_BIT_RDATA == $past(port3_read_bit);
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test result wrong");

  property p_bit_write_other;
    @(posedge I_MCLK) disable iff (I_SYS_RST) (I_WR && I_BIT_OP && I_BIT_SEL != 3'h0) |=> $stable(port3_bit0_q);
  endproperty
  a_bit_write_other: assert property (p_bit_write_other) else $error("bit write hit bit 0");

  property p_bit_op_byte_regs;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && I_BIT_OP) |=> $stable(p0_mode_a_q) && $stable(pin20_setup_q);
  endproperty
  a_bit_op_byte_regs: assert property (p_bit_op_byte_regs) else $error("bit access changed a byte register");

  property p_bit_high_zero;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_RD && I_BIT_OP && I_ADDR == ADDR_PORT3_DATA && I_BIT_SEL != 3'h0) |=> !O_BIT_RDATA;
  endproperty
  a_bit_high_zero: assert property (p_bit_high_zero) else $error("high bit test not zero");

  property p_page0_steer;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      (I_WR && !I_BIT_OP && page0 && I_ADDR == ADDR_P1_SHARED_B) |=> $stable(p1_slew_q);
  endproperty
  a_page0_steer: assert property (p_page0_steer) else $error("page0 write reached page1");

  property p_port3_hold;
    @(posedge I_MCLK) disable iff (I_SYS_RST) (!wr_p3_byte && !wr_p3_bit) |=> $stable(port3_bit0_q);
  endproperty
  a_port3_hold: assert property (p_port3_hold) else $error("port3 bit changed with no write");

endmodule : ppc_port_cfg

// [testbench/ppc_pin_model.sv]
// Model of the port 3 bit 0 pad and what hangs on it.
// Assumes the block's data bit and GPIO enable drive the pad, and an external clock runs otherwise.
`timescale 1ns/100ps
module ppc_pin_model (
  input  wire logic i_clk,
  input  wire logic i_drive,
  input  wire logic i_drive_en,
  output logic      o_pin
);
  logic osc_q = 1'b0;

  // A free-running external clock keeps the pad moving, so a stale level can never pass for data.
  always_ff @(posedge i_clk) begin
    osc_q <= !osc_q;
  end

  assign o_pin = i_drive_en ? i_drive : osc_q;
endmodule : ppc_pin_model

// [testbench/ppc_port_cfg_test.sv]
// Self-checking testbench for the port pin configuration registers.
// Assumes the pad model on port 3 bit 0 and strobe accesses on the register port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module ppc_port_cfg_test
  import ppc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bop = 1'b0, bval = 1'b0, page = 1'b0;
  logic osc = 1'b1, reset_pin_disable_cfg = 1'b1, pin, ta = 1'b0, tb = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] bsel = 3'h0;
  logic [15:0] m0, m1;
  logic [7:0] s0, s1, f0, f1;
  logic p3o, gpio, ext, pu, ps, tap, taoe, tbp, tboe, brd;
  int n_errors = 0, n_tests = 0;

  always #5 clk = !clk;

  ppc_port_cfg i_dut (.I_MCLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_BIT_OP(bop), .I_BIT_SEL(bsel), .I_BIT_VAL(bval), .I_PAGE(page), .I_INT_OSC_SEL(osc),
    .I_RESET_PIN_DISABLE_CFG(reset_pin_disable_cfg), .I_PORT3_BIT0_PIN(pin), .I_TIMER_A_OUT(ta), .I_TIMER_B_OUT(tb),
    .O_RDATA(rdata), .O_BIT_RDATA(brd), .O_PORT0_MODE(m0), .O_PORT1_MODE(m1), .O_PORT0_SCHMITT(s0),
    .O_PORT1_SCHMITT(s1), .O_PORT0_SLEW_FAST(f0), .O_PORT1_SLEW_FAST(f1), .O_PORT3_BIT0_OUT(p3o),
    .O_PORT3_GPIO_EN(gpio), .O_EXTERNAL_CLOCK_INPUT(ext), .O_PIN20_PULLUP(pu), .O_PIN20_SCHMITT(ps),
    .O_TIMER_A_PIN(tap), .O_TIMER_A_PIN_OE(taoe), .O_TIMER_B_PIN(tbp), .O_TIMER_B_PIN_OE(tboe));

  ppc_pin_model i_pad (.i_clk(clk), .i_drive(p3o), .i_drive_en(gpio), .o_pin(pin));

  task automatic results();
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // One strobe cycle; the bit value of a bit access rides on data bit 0.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic pg,
                     input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(posedge clk);
    wr    <= w;
    rd    <= !w;
    addr  <= a;
    wdata <= d;
    page  <= pg;
    bop   <= b;
    bsel  <= s;
    bval  <= d[0];
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b0;
    bop   <= 1'b0;
    #1;
  endtask : bus

  task automatic rdc(input string n, input logic [7:0] a, input logic pg, input logic [7:0] e);
    bus(1'b0, a, 8'h00, pg);
    `CHK(n, e, rdata)
  endtask : rdc

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      rdc("reset value", 8'(8'hb1 + i / 2), 1'(i % 2), (i % 4 == 0 && i < 8) ? 8'hff : 8'h00);
    end
    `CHK("p3 bit0 reset", 1'b1, p3o)
    bus(1'b1, ADDR_PORT3_DATA, 8'hfe, 1'b0);
    `CHK("p3 byte write", 1'b0, p3o)
    bus(1'b1, ADDR_PORT3_DATA, 8'h01, 1'b0, 1'b1, 3'h0);
    bus(1'b1, ADDR_PORT3_DATA, 8'h01, 1'b0, 1'b1, 3'h5);
    repeat (4) @(posedge clk);
    rdc("p3 read", ADDR_PORT3_DATA, 1'b0, 8'h01);
    bus(1'b0, ADDR_PORT3_DATA, 8'h00, 1'b0, 1'b1, 3'h0);
    `CHK("p3 bit test set", 1'b1, brd)
    bus(1'b0, ADDR_PORT3_DATA, 8'h00, 1'b0, 1'b1, 3'h5);
    `CHK("p3 bit test high", 1'b0, brd)
    bus(1'b1, ADDR_PORT3_DATA, 8'h00, 1'b0, 1'b1, 3'h0);
    repeat (4) @(posedge clk);
    bus(1'b0, ADDR_PORT3_DATA, 8'h00, 1'b0, 1'b1, 3'h0);
    `CHK("p3 bit test", 1'b0, brd)
    osc <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("ext clock", 2'b01, {gpio, ext})
    bus(1'b1, ADDR_PORT3_DATA, 8'hff, 1'b0);
    `CHK("p3 write ignored", 1'b0, p3o)
    rdc("p3 ext read", ADDR_PORT3_DATA, 1'b0, 8'h00);
    osc <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, 8'(8'hb1 + 2 * p), 8'h0c, 1'b0);
      bus(1'b1, 8'(8'hb2 + 2 * p), 8'h0a, 1'b0);
      bus(1'b1, 8'(8'hb1 + 2 * p), 8'h5a, 1'b1);
      bus(1'b1, 8'(8'hb2 + 2 * p), 8'ha5, 1'b1);
      `CHK("mode", {8'h00, MODE_OPEN_DRAIN, MODE_INPUT_ONLY, MODE_PUSH_PULL, MODE_QUASI}, p ? m1 : m0)
      `CHK("schmitt", 8'h5a, p ? s1 : s0)
      `CHK("slew", 8'ha5, p ? f1 : f0)
      rdc("page0 mode", 8'(8'hb1 + 2 * p), 1'b0, 8'h0c);
      rdc("page1 slew", 8'(8'hb2 + 2 * p), 1'b1, 8'ha5);
      rdc("page0 mode b", 8'(8'hb2 + 2 * p), 1'b0, 8'h0a);
      rdc("page1 schmitt", 8'(8'hb1 + 2 * p), 1'b1, 8'h5a);
    end
    // Timer outputs stay in timer mode here, as software is expected to arrange.
    ta <= 1'b1;
    tb <= 1'b1;
    reset_pin_disable_cfg <= 1'b1;
    bus(1'b1, ADDR_PIN20_SETUP, 8'h00, 1'b0);
    `CHK("pullup forced", 1'b1, pu)
    `CHK("timers off", 4'h0, {tap, taoe, tbp, tboe})
    reset_pin_disable_cfg <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("pullup off", 1'b0, pu)
    bus(1'b1, ADDR_PIN20_SETUP, 8'hff, 1'b0);
    rdc("pin20 setup", ADDR_PIN20_SETUP, 1'b0, PIN20_SETUP_MASK);
    `CHK("pullup on", 1'b1, pu)
    `CHK("pin20 schmitt", 1'b1, ps)
    `CHK("timers on", 4'hf, {tap, taoe, tbp, tboe})
    ta <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("timer a follows", 2'b01, {tap, taoe})
    rdc("unmapped", 8'hb6, 1'b0, 8'h00);
    results();
  end
endmodule : ppc_port_cfg_test
